// ---- verilog/vvt_top.sv ----
// Raster timing for a bit-mapped video generator: horizontal tail, vertical sequencer,
// digital mains phase loop and a small register port.
// Assumes all inputs are synchronous to mclk and table_sixty_hertz is static.
//
// Overview of operation
// - Line sync on 48h..4Fh group, permit at sixth position, group occurs ten times.
// - Vertical word bits: blanking, frame sync, mains-lock sync, counter reload.
// - Frame sync output keeps the monitor vertical sweep in step with pixels.
// - Serial video is forced to zero while retrace blanking is high.
// - Mains-lock sync feeds the phase loop and sets a readable display flag.
// - Start-scan value is copied into the scan counter at each scan start.
// - One of two vertical tables is used, sixty or fifty hertz mains.
// - Phase loop compares mains-lock sync with mains and trims cell clock rate.
// - Cell clock steps the dot counter, which steps the vertical sequencer.
// - Sixty hertz entries 00..32 give mains-lock sync only, 102 lines.
// - Sixty hertz 78..83 blank with lock sync, frame sync inside, reload at 83.
// - Sixty hertz addresses 84..FF give blanking with lock sync only and are never reached.
// - Fifty hertz entries 00..29 give mains-lock sync only, 84 lines.
// - Fifty hertz 80..9A give all three syncs; 9B, 9C blank, lock, reload.
// - Fifty hertz addresses 9D..FF give blanking with lock sync only and are never reached.
// - Scan counter increments by one on every line without the reload bit.
// - Video is blanked while the display enable control bit is high.
// - Line sync first rises at dot position 48h after the fetch pattern.
//
// The plain strobed port and the register addresses were left to the implementer.
`default_nettype none
`include "vvt_defs.svh"
module vvt_top
    import vvt_pkg::*;
#(
    parameter int LINES_PER_ENTRY = 2
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic table_sixty_hertz,
    input wire logic mains_ref,
    input wire logic [7:0] pixel_byte,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [7:0] dot_count,
    output logic [7:0] scan_count,
    output logic pixel_out,
    output logic line_sync_pulse,
    output logic cpu_slot_permit,
    output logic vertical_out_bit3,
    output logic vertical_out_bit2,
    output logic vertical_out_bit1,
    output logic vertical_out_bit0,
    output logic display_flag
);
    // The line parity is the tap that paces the table, so one or two lines per entry fit.
    // One line per entry is only useful to shorten frames when checking the tables.
    if (LINES_PER_ENTRY != 1 && LINES_PER_ENTRY != 2) begin : g_bad_lines
        $error("vvt_top: LINES_PER_ENTRY must be 1 or 2");
    end

    vvt_state_type st;
    vvt_state_type next_st;

    function automatic logic [3:0] vt_sixty(input logic [7:0] a);
        if (a <= `VVT_V60_SYNC_END) begin
            return `VVT_VOUT_LOCK;
        end else if (a <= `VVT_V60_WAIT_END) begin
            return `VVT_VOUT_WAIT;
        end else if (a >= `VVT_V60_VSYNC_FIRST && a <= `VVT_V60_VSYNC_LAST) begin
            return `VVT_VOUT_FRAME;
        end else if (a == `VVT_V60_LAST) begin
            return `VVT_VOUT_RELOAD;
        end else begin
            // Entries past the last one repeat the blanking tail and are never reached.
            return `VVT_VOUT_BLANK;
        end
    endfunction : vt_sixty

    function automatic logic [3:0] vt_fifty(input logic [7:0] a);
        if (a <= `VVT_V50_SYNC_END) begin
            return `VVT_VOUT_LOCK;
        end else if (a <= `VVT_V50_WAIT_END) begin
            return `VVT_VOUT_WAIT;
        end else if (a >= `VVT_V50_VSYNC_FIRST && a <= `VVT_V50_VSYNC_LAST) begin
            return `VVT_VOUT_FRAME;
        end else if (a > `VVT_V50_VSYNC_LAST && a <= `VVT_V50_LAST) begin
            return `VVT_VOUT_RELOAD;
        end else begin
            return `VVT_VOUT_BLANK;
        end
    endfunction : vt_fifty

    function automatic logic in_hsync(input logic [7:0] d);
        return d >= `VVT_HSYNC_FIRST && d <= `VVT_HSYNC_LAST;
    endfunction : in_hsync

    function automatic logic in_permit(input logic [7:0] d);
        logic fetch_or_sync;
        fetch_or_sync = (d < `VVT_FETCH_END) || in_hsync(d) || (d == 8'h45);
        return (fetch_or_sync && d[2:0] == `VVT_PERMIT_PHASE)
            || d == `VVT_TAIL_PERMIT_A || d == `VVT_TAIL_PERMIT_B;
    endfunction : in_permit

    logic [16:0] acc_sum;
    logic cell_tick;
    logic line_end;
    logic [7:0] last_entry;
    logic [3:0] vt_next;

    assign acc_sum = {1'b0, st.acc} + {1'b0, st.incr};
    assign cell_tick = acc_sum[16];
    assign line_end = st.dot == 8'hFF;
    assign last_entry = table_sixty_hertz ? `VVT_V60_LAST : `VVT_V50_LAST;

    always_comb begin
        next_st = st;
        vt_next = st.vout;
        next_st.acc = acc_sum[15:0];
        next_st.mains_q = mains_ref;
        // The phase loop: a mains edge seen while lock sync is high means the raster runs
        // early, so the cell clock slows; otherwise it speeds up. Clamped to stay stable.
        if (mains_ref && !st.mains_q) begin
            // The step saturates, so an edge near a limit lands exactly on that limit.
            if (st.vout[1]) begin
                if (st.incr > `VVT_INCR_MIN + `VVT_INCR_STEP) begin
                    next_st.incr = st.incr - `VVT_INCR_STEP;
                end else begin
                    next_st.incr = `VVT_INCR_MIN;
                end
            end else if (st.incr < `VVT_INCR_MAX - `VVT_INCR_STEP) begin
                next_st.incr = st.incr + `VVT_INCR_STEP;
            end else begin
                next_st.incr = `VVT_INCR_MAX;
            end
        end
        if (cell_tick) begin
            next_st.dot = st.dot + 8'h01;
            next_st.hsync = in_hsync(next_st.dot);
            next_st.permit = in_permit(next_st.dot);
            if (next_st.dot < `VVT_FETCH_END && next_st.dot[2:0] == `VVT_LOAD_PHASE) begin
                next_st.shreg = pixel_byte;
            end else begin
                next_st.shreg = {st.shreg[6:0], 1'b0};
            end
            next_st.pix = st.shreg[7] & ~st.vout[3] & ~st.disp_ctl;
            if (line_end) begin
                next_st.line_par = ~st.line_par;
                if (st.vout[0]) begin
                    next_st.vscan = st.start_scan;
                end else begin
                    next_st.vscan = st.vscan + 8'h01;
                end
                if (st.line_par || LINES_PER_ENTRY == 1) begin
                    next_st.vaddr = (st.vaddr >= last_entry) ? 8'h00 : st.vaddr + 8'h01;
                    vt_next = table_sixty_hertz ? vt_sixty(next_st.vaddr)
                                                : vt_fifty(next_st.vaddr);
                    next_st.vout = vt_next;
                end
            end
        end
        if (vt_next[1] && !st.vout[1]) begin
            next_st.disp_flag = 1'b1;
        end else if (reg_rd && reg_addr == `VVT_ADDR_STATUS) begin
            next_st.disp_flag = 1'b0;
        end
        if (reg_wr) begin
            if (reg_addr == `VVT_ADDR_START_SCAN) begin
                next_st.start_scan = reg_wdata;
            end else if (reg_addr == `VVT_ADDR_CONTROL) begin
                next_st.disp_ctl = reg_wdata[0];
            end else if (reg_addr == `VVT_ADDR_INCR_LO) begin
                next_st.incr[7:0] = reg_wdata;
            end else if (reg_addr == `VVT_ADDR_INCR_HI) begin
                next_st.incr[15:8] = reg_wdata;
            end
        end
        next_st.rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == `VVT_ADDR_START_SCAN) begin
                next_st.rdata = st.start_scan;
            end else if (reg_addr == `VVT_ADDR_CONTROL) begin
                next_st.rdata = {7'h00, st.disp_ctl};
            end else if (reg_addr == `VVT_ADDR_STATUS) begin
                next_st.rdata = {3'h0, st.disp_flag, st.vout};
            end else if (reg_addr == `VVT_ADDR_INCR_LO) begin
                next_st.rdata = st.incr[7:0];
            end else if (reg_addr == `VVT_ADDR_INCR_HI) begin
                next_st.rdata = st.incr[15:8];
            end else if (reg_addr == `VVT_ADDR_SCAN_COUNT) begin
                next_st.rdata = st.vscan;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.incr <= `VVT_INCR_RESET;
            st.vout <= `VVT_VOUT_LOCK;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign dot_count = st.dot;
    assign scan_count = st.vscan;
    assign pixel_out = st.pix;
    assign line_sync_pulse = st.hsync;
    assign cpu_slot_permit = st.permit;
    assign vertical_out_bit3 = st.vout[3];
    assign vertical_out_bit2 = st.vout[2];
    assign vertical_out_bit1 = st.vout[1];
    assign vertical_out_bit0 = st.vout[0];
    assign display_flag = st.disp_flag;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    a_sync_window: assert property (line_sync_pulse |-> in_hsync(st.dot))
        else $error("line sync outside its window");
    a_permit_group: assert property (
        (cell_tick && in_hsync(st.dot + 8'h01) && st.dot[2:0] == 3'h4)
            |=> (line_sync_pulse && cpu_slot_permit))
        else $error("slot permit missing in line sync group");
    a_blank_video: assert property (
        (cell_tick && vertical_out_bit3) |=> !pixel_out)
        else $error("video not blanked during retrace");
    a_ctl_blank: assert property ((cell_tick && st.disp_ctl) |=> !pixel_out)
        else $error("video not blanked by display control");
    a_scan_reload: assert property (
        (cell_tick && line_end && vertical_out_bit0)
            |=> scan_count == $past(st.start_scan))
        else $error("scan counter not reloaded");
    a_scan_step: assert property (
        (cell_tick && line_end && !vertical_out_bit0)
            |=> scan_count == $past(scan_count) + 8'h01)
        else $error("scan counter did not step");
    a_dot_hold: assert property (!cell_tick |=> $stable(dot_count))
        else $error("dot counter moved without cell clock");
    a_flag_set: assert property ($rose(vertical_out_bit1) |-> display_flag)
        else $error("display flag not set by lock sync");
    a_sixty_lock: assert property (
        (table_sixty_hertz && st.vaddr <= `VVT_V60_SYNC_END) |-> st.vout == 4'h2)
        else $error("sixty hertz lock span wrong");
    a_fifty_frame: assert property (
        (!table_sixty_hertz && st.vaddr >= 8'h80 && st.vaddr <= 8'h9A)
            |-> st.vout == 4'hE)
        else $error("fifty hertz frame span wrong");
    a_table_wrap: assert property (st.vaddr <= last_entry)
        else $error("table address past last entry");

    // Horizontal tail: entry into and exit from the line sync group, and the slot permits.
    a_sync_entry: assert property (
        (cell_tick && st.dot == 8'h47) |=> line_sync_pulse)
        else $error("line sync did not start at its first position");

    a_sync_exit: assert property (
        (cell_tick && st.dot == 8'h97) |=> !line_sync_pulse)
        else $error("line sync ran past its last group");

    a_sync_fetch: assert property (
        (st.dot < 8'h48) |-> !line_sync_pulse)
        else $error("line sync during the fetch pattern");

    a_permit_fetch: assert property (
        (cell_tick && st.dot < 8'h3F && st.dot[2:0] == 3'h4) |=> cpu_slot_permit)
        else $error("slot permit missing in fetch pattern");

    a_permit_tail: assert property (
        (cell_tick && (st.dot == 8'h9D || st.dot == 8'hA5)) |=> cpu_slot_permit)
        else $error("slot permit missing in line tail");

    a_dot_wrap: assert property (
        (cell_tick && line_end) |=> dot_count == 8'h00)
        else $error("dot counter did not wrap at line end");

    a_pixel_hold: assert property (
        !cell_tick |=> $stable(pixel_out))
        else $error("video moved without cell clock");

    // Vertical side: everything moves only at a line end, and the word keeps its shape.
    a_scan_hold: assert property (
        !(cell_tick && line_end) |=> $stable(scan_count))
        else $error("scan counter moved inside a line");

    a_vout_hold: assert property (
        !(cell_tick && line_end) |=> $stable(st.vout))
        else $error("vertical word moved inside a line");

    a_vaddr_hold: assert property (
        !(cell_tick && line_end) |=> $stable(st.vaddr))
        else $error("table address moved inside a line");

    a_vaddr_wrap: assert property (
        (cell_tick && line_end && (st.line_par || LINES_PER_ENTRY == 1)
            && st.vaddr == last_entry) |=> st.vaddr == 8'h00)
        else $error("table address did not wrap");

    a_reload_blank: assert property (
        vertical_out_bit0 |-> (vertical_out_bit3 && vertical_out_bit1))
        else $error("scan reload outside blanking");

    a_frame_blank: assert property (
        vertical_out_bit2 |-> vertical_out_bit3)
        else $error("frame sync outside blanking");

    a_sixty_wait: assert property (
        (table_sixty_hertz && st.vaddr > 8'h32 && st.vaddr <= 8'h77) |-> st.vout == 4'h0)
        else $error("sixty hertz wait span wrong");

    a_sixty_frame: assert property (
        (table_sixty_hertz && st.vaddr >= 8'h79 && st.vaddr <= 8'h7F) |-> st.vout == 4'hE)
        else $error("sixty hertz frame span wrong");

    a_sixty_reload: assert property (
        (table_sixty_hertz && st.vaddr == 8'h83) |-> st.vout == 4'hB)
        else $error("sixty hertz reload entry wrong");

    a_fifty_lock: assert property (
        (!table_sixty_hertz && st.vaddr <= 8'h29) |-> st.vout == 4'h2)
        else $error("fifty hertz lock span wrong");

    a_fifty_wait: assert property (
        (!table_sixty_hertz && st.vaddr >= 8'h2A && st.vaddr <= 8'h77) |-> st.vout == 4'h0)
        else $error("fifty hertz wait span wrong");

    a_fifty_reload: assert property (
        (!table_sixty_hertz && st.vaddr >= 8'h9B && st.vaddr <= 8'h9C) |-> st.vout == 4'hB)
        else $error("fifty hertz reload entries wrong");

    // Display flag and phase loop limits.
    a_flag_hold: assert property (
        (display_flag && !(reg_rd && reg_addr == `VVT_ADDR_STATUS)) |=> display_flag)
        else $error("display flag lost without a read");

    a_flag_clear: assert property (
        (reg_rd && reg_addr == `VVT_ADDR_STATUS && !(vt_next[1] && !st.vout[1]))
            |=> !display_flag)
        else $error("display flag not cleared by read");

    a_loop_floor: assert property (
        (mains_ref && !st.mains_q && st.vout[1] && !reg_wr) |=> st.incr >= `VVT_INCR_MIN)
        else $error("phase loop went below its floor");

    a_loop_ceiling: assert property (
        (mains_ref && !st.mains_q && !st.vout[1] && !reg_wr) |=> st.incr <= `VVT_INCR_MAX)
        else $error("phase loop went above its ceiling");
endmodule : vvt_top
`default_nettype wire

// ---- verilog/vvt_defs.svh ----
// Constants for the raster timing block: register offsets, table marks, reset values.
// Assumes inclusion by the package, the top module and the bench.
`ifndef VVT_DEFS_SVH
`define VVT_DEFS_SVH

`define VVT_ADDR_START_SCAN 8'h00
`define VVT_ADDR_CONTROL 8'h01
`define VVT_ADDR_STATUS 8'h02
`define VVT_ADDR_INCR_LO 8'h03
`define VVT_ADDR_INCR_HI 8'h04
`define VVT_ADDR_SCAN_COUNT 8'h05

`define VVT_HSYNC_FIRST 8'h48
`define VVT_HSYNC_LAST 8'h97
`define VVT_FETCH_END 8'h40
`define VVT_PERMIT_PHASE 3'h5
`define VVT_LOAD_PHASE 3'h2
`define VVT_TAIL_PERMIT_A 8'h9E
`define VVT_TAIL_PERMIT_B 8'hA6

`define VVT_V60_SYNC_END 8'h32
`define VVT_V60_WAIT_END 8'h77
`define VVT_V60_VSYNC_FIRST 8'h79
`define VVT_V60_VSYNC_LAST 8'h7F
`define VVT_V60_LAST 8'h83
`define VVT_V50_SYNC_END 8'h29
`define VVT_V50_WAIT_END 8'h77
`define VVT_V50_VSYNC_FIRST 8'h79
`define VVT_V50_VSYNC_LAST 8'h9A
`define VVT_V50_LAST 8'h9C

`define VVT_VOUT_LOCK 4'h2
`define VVT_VOUT_WAIT 4'h0
`define VVT_VOUT_BLANK 4'hA
`define VVT_VOUT_FRAME 4'hE
`define VVT_VOUT_RELOAD 4'hB

`define VVT_INCR_RESET 16'h8000
`define VVT_INCR_STEP 16'h0010
`define VVT_INCR_MIN 16'h4000
`define VVT_INCR_MAX 16'hC000

`endif

// ---- verilog/vvt_pkg.sv ----
// Types shared by the raster timing block.
// Assumes vvt_defs.svh is on the include path.
`default_nettype none
`include "vvt_defs.svh"
package vvt_pkg;
    typedef struct packed {
        logic [15:0] acc;
        logic [15:0] incr;
        logic [7:0] dot;
        logic line_par;
        logic [7:0] vaddr;
        logic [3:0] vout;
        logic [7:0] vscan;
        logic [7:0] start_scan;
        logic disp_ctl;
        logic disp_flag;
        logic mains_q;
        logic [7:0] shreg;
        logic pix;
        logic hsync;
        logic permit;
        logic [7:0] rdata;
    } vvt_state_type;
endpackage : vvt_pkg
`default_nettype wire

// ---- tb/vvt_mains_model.sv ----
// Mains reference model: one rising edge of the mains square wave on each request.
// Assumes one-cycle requests spaced wider than the hold time.
`default_nettype none
module vvt_mains_model #(
    parameter int HOLD = 4
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic rise_req,
    output logic mains_ref
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
        end else if (rise_req) begin
            cnt <= HOLD;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    // The loop reacts to the edge, so the level is held a few cycles to be seen clearly.
    assign mains_ref = (cnt > 0);
endmodule : vvt_mains_model
`default_nettype wire

// ---- tb/test_vvt_top.sv ----
// Self-checking bench for the raster timing block: register port, raster and both tables.
// Assumes vvt_top built with one line per table entry to keep frames short.
`default_nettype none
`include "vvt_defs.svh"
module test_vvt_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic sixty = 1'b1;
    logic rise_req = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] start_val = 8'h00;
    logic ctl_on = 1'b0;
    logic lit_seen = 1'b0;
    logic mains_ref, pixel_out, line_sync_pulse, cpu_slot_permit, display_flag;
    logic exp_sync, exp_permit;
    logic [3:0] prev_v;
    wire logic [3:0] vbits;
    logic [7:0] reg_rdata, dot_count, scan_count, prev_dot, exp_scan;
    int lines, quiet_age, bad_count, checks;

    vvt_top #(.LINES_PER_ENTRY(1)) dut (
        .mclk(mclk), .nrst(nrst), .table_sixty_hertz(sixty), .mains_ref(mains_ref),
        .pixel_byte(8'hFF), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dot_count(dot_count),
        .scan_count(scan_count), .pixel_out(pixel_out), .line_sync_pulse(line_sync_pulse),
        .cpu_slot_permit(cpu_slot_permit), .vertical_out_bit3(vbits[3]),
        .vertical_out_bit2(vbits[2]), .vertical_out_bit1(vbits[1]),
        .vertical_out_bit0(vbits[0]), .display_flag(display_flag)
    );
    vvt_mains_model mains (.mclk(mclk), .nrst(nrst), .rise_req(rise_req), .mains_ref(mains_ref));

    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic check_bit(input string what, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", what, e, g);
        end
    endtask : check_bit

    task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : check_byte

    task automatic report_and_stop();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic read_check(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        check_byte(what, e, reg_rdata);
    endtask : read_check

    task automatic mains_rise();
        @(posedge mclk);
        rise_req <= 1'b1;
        @(posedge mclk);
        rise_req <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask : mains_rise

    task automatic wait_lines(input int n);
        for (int i = 0; i < 90000 && lines < n; i++) begin
            @(posedge mclk);
        end
        if (lines < n) begin
            bad_count++;
            $display("wrong value line count expected %0d seen %0d", n, lines);
            report_and_stop();
        end
    endtask : wait_lines

    task automatic do_reset(input logic s);
        nrst <= 1'b0;
        sixty <= s;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
    endtask : do_reset

    function automatic logic [3:0] vexp(input int e, input logic s);
        int n;
        n = s ? e % 8'h84 : e % 8'h9D;
        if (n <= (s ? 8'h32 : 8'h29)) return 4'h2;
        if (n <= 8'h77) return 4'h0;
        if (n == 8'h78) return 4'hA;
        if (n <= (s ? 8'h7F : 8'h9A)) return 4'hE;
        if (s && n <= 8'h82) return 4'hA;
        return 4'hB;
    endfunction : vexp

    // Sampled at the falling edge so every registered output has settled.
    always @(negedge mclk) begin
        if (!nrst) begin
            lines = 0;
            exp_scan = 8'h00;
            prev_dot = 8'h00;
            prev_v = 4'h2;
            quiet_age = 0;
        end else begin
            quiet_age = (vbits[3] || ctl_on) ? quiet_age + 1 : 0;
            if (quiet_age >= 3) check_bit("blanked video", 1'b0, pixel_out);
            if (pixel_out === 1'b1) lit_seen = 1'b1;
            if (dot_count !== prev_dot) begin
                if (dot_count == 8'h00) begin
                    lines++;
                    exp_scan = prev_v[0] ? start_val : exp_scan + 8'h01;
                end
                exp_sync = dot_count >= 8'h48 && dot_count <= 8'h97;
                exp_permit = dot_count <= 8'h97 && dot_count[2:0] == 3'h5;
                exp_permit = exp_permit || dot_count == 8'h9E || dot_count == 8'hA6;
                check_byte("dot step", prev_dot + 8'h01, dot_count);
                check_bit("line sync", exp_sync, line_sync_pulse);
                check_bit("slot permit", exp_permit, cpu_slot_permit);
                check_byte("vertical bits", {4'h0, vexp(lines, sixty)}, {4'h0, vbits});
                check_byte("scan count", exp_scan, scan_count);
                prev_v = vbits;
                prev_dot = dot_count;
            end
        end
    end

    initial begin
        bad_count = 0;
        checks = 0;
        do_reset(1'b1);
        check_byte("vertical bits at reset", 8'h02, {4'h0, vbits});
        reg_write(`VVT_ADDR_START_SCAN, 8'h30);
        start_val = 8'h30;
        read_check(`VVT_ADDR_START_SCAN, 8'h30, "start scan");
        @(negedge mclk);
        check_byte("read data after", 8'h00, reg_rdata);
        reg_write(8'h7E, 8'h5A);
        read_check(8'h7E, 8'h00, "unmapped");
        reg_write(`VVT_ADDR_INCR_LO, 8'h05);
        reg_write(`VVT_ADDR_INCR_HI, 8'h40);
        mains_rise();
        read_check(`VVT_ADDR_INCR_LO, 8'h00, "incr low lowered");
        read_check(`VVT_ADDR_INCR_HI, 8'h40, "incr high lowered");
        reg_write(`VVT_ADDR_INCR_LO, 8'hFF);
        reg_write(`VVT_ADDR_INCR_HI, 8'hFF);
        wait_lines(8'h34);
        read_check(`VVT_ADDR_STATUS, 8'h00, "status in wait span");
        reg_write(`VVT_ADDR_INCR_LO, 8'hF8);
        reg_write(`VVT_ADDR_INCR_HI, 8'hBF);
        mains_rise();
        read_check(`VVT_ADDR_INCR_LO, 8'h00, "incr low raised");
        read_check(`VVT_ADDR_INCR_HI, 8'hC0, "incr high raised");
        reg_write(`VVT_ADDR_INCR_LO, 8'hFF);
        reg_write(`VVT_ADDR_INCR_HI, 8'hFF);
        reg_write(`VVT_ADDR_CONTROL, 8'h01);
        ctl_on = 1'b1;
        read_check(`VVT_ADDR_CONTROL, 8'h01, "control");
        repeat (600) @(posedge mclk);
        reg_write(`VVT_ADDR_CONTROL, 8'h00);
        ctl_on = 1'b0;
        wait_lines(8'h84 + 3);
        check_bit("lit video", 1'b1, lit_seen);
        read_check(`VVT_ADDR_STATUS, 8'h12, "status flag set");
        read_check(`VVT_ADDR_STATUS, 8'h02, "status flag cleared");
        do_reset(1'b0);
        reg_write(`VVT_ADDR_START_SCAN, 8'h55);
        start_val = 8'h55;
        reg_write(`VVT_ADDR_INCR_LO, 8'hFF);
        reg_write(`VVT_ADDR_INCR_HI, 8'hFF);
        wait_lines(8'h9D + 3);
        report_and_stop();
    end
endmodule : test_vvt_top
`default_nettype wire
